// File: touch_status_report_regs.sv
// read-side status reporting bank of a capacitive trackpad controller
// assumes the host port decodes serial transfers into byte reads/writes
// and that the sensing engine drives flags synchronous to i_core_clk
`timescale 1ns/10ps
`default_nettype none
module touch_status_report_regs import touch_status_pkg::*; #(
   parameter int unsigned ROWS = TX_ROWS,
   parameter int unsigned COLS = RX_COLS
) (
   input  wire logic                 i_core_clk,
   input  wire logic                 i_sys_rst,
   // host byte port
   input  wire logic                 i_rd_en,
   input  wire logic [15:0]          i_rd_addr,
   input  wire logic                 i_wr_en,
   input  wire logic [15:0]          i_wr_addr,
   input  wire logic [7:0]           i_wr_data,
   output logic      [7:0]           o_rd_data,
   output logic                      o_rd_valid,
   // sensing engine events and levels
   input  wire logic                 i_cycle_start,
   input  wire logic                 i_gesture_valid,
   input  wire logic [5:0]           i_gesture_single,
   input  wire logic [2:0]           i_gesture_multi,
   input  wire logic                 i_lowpower_retune_done,
   input  wire logic                 i_lowpower_tune_fault,
   input  wire logic                 i_pad_retune_done,
   input  wire logic                 i_pad_tune_fault,
   input  wire logic [2:0]           i_mode,
   input  wire logic                 i_switch_input_pin,
   input  wire logic                 i_snap_change,
   input  wire logic                 i_rate_miss_flag,
   input  wire logic                 i_finger_overflow_flag,
   input  wire logic                 i_palm_flag,
   input  wire logic                 i_pad_motion_flag,
   // per-channel live status maps, index tx*COLS+rx
   input  wire logic [ROWS*COLS-1:0] i_prox_map,
   input  wire logic [ROWS*COLS-1:0] i_touch_map,
   input  wire logic [ROWS*COLS-1:0] i_snap_map,
   input  wire logic                 i_alt_lowpower_prox,
   // per-channel value write port
   input  wire logic                 i_val_wr_en,
   input  wire logic [1:0]           i_val_sel,
   input  wire logic [7:0]           i_val_idx,
   input  wire logic [15:0]          i_val_data,
   // configuration maps towards the sensing engine
   output logic      [ROWS*COLS-1:0] o_active_map,
   output logic      [ROWS*COLS-1:0] o_snap_enable_map,
   output logic                      o_show_reset
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0]           gest_single;
      logic [2:0]           gest_multi;
      logic                 show_reset;
      logic                 lowpower_retune_done;
      logic                 lowpower_tune_fault;
      logic                 pad_retune_done;
      logic                 pad_tune_fault;
      logic [2:0]           mode;
      logic                 switch_state;
      logic                 snap_toggle;
      logic                 rate_miss;
      logic                 finger_over;
      logic                 palm;
      logic                 motion;
      logic [ROWS*COLS-1:0] active;
      logic [ROWS*COLS-1:0] snap_en;
      logic [7:0]           rd_data;
      logic                 rd_valid;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // ----------------------------------------------------------------
   // address decode helpers
   // ----------------------------------------------------------------
   logic [15:0] prox_rel;
   logic [15:0] touch_rel;
   logic [15:0] snap_rel;
   logic [15:0] active_rel;
   logic [15:0] snapen_rel;
   logic [15:0] count_rel;
   logic [15:0] delta_rel;
   logic [15:0] ref_rel;
   logic [15:0] wr_active_rel;
   logic [15:0] wr_snapen_rel;
   logic [7:0]  prox_byte;
   logic [7:0]  touch_byte;
   logic [7:0]  snap_byte;
   logic [7:0]  active_byte;
   logic [7:0]  snapen_byte;
   logic [7:0]  count_byte;
   logic [7:0]  delta_byte;
   logic [7:0]  ref_byte;
   logic [7:0]  rd_byte;
   logic [7:0]  sysinfo_pri;
   logic [7:0]  sysinfo_sec;

   // relative offsets; wrap-around on low addresses fails the range check
   assign prox_rel      = i_rd_addr - ADDR_PROX_BASE;
   assign touch_rel     = i_rd_addr - ADDR_TOUCH_BASE;
   assign snap_rel      = i_rd_addr - ADDR_SNAP_BASE;
   assign active_rel    = i_rd_addr - ADDR_ACTIVE_BASE;
   assign snapen_rel    = i_rd_addr - ADDR_SNAPEN_BASE;
   assign count_rel     = i_rd_addr - ADDR_COUNT_BASE;
   assign delta_rel     = i_rd_addr - ADDR_DELTA_BASE;
   assign ref_rel       = i_rd_addr - ADDR_REF_BASE;
   assign wr_active_rel = i_wr_addr - ADDR_ACTIVE_BASE;
   assign wr_snapen_rel = i_wr_addr - ADDR_SNAPEN_BASE;

   // ----------------------------------------------------------------
   // bitmap byte lanes
   // ----------------------------------------------------------------
   // proximity extra word
   bitmap_byte_pick #(.ROWS(ROWS), .COLS(COLS), .EXTRA(1'b1)) u_prox_pick (
      .i_map       (i_prox_map),
      .i_extra_bit (i_alt_lowpower_prox),
      .i_offset    (prox_rel[4:0]),
      .o_byte      (prox_byte)
   );

   bitmap_byte_pick #(.ROWS(ROWS), .COLS(COLS), .EXTRA(1'b0)) u_touch_pick (
      .i_map       (i_touch_map),
      .i_extra_bit (1'b0),
      .i_offset    (touch_rel[4:0]),
      .o_byte      (touch_byte)
   );

   bitmap_byte_pick #(.ROWS(ROWS), .COLS(COLS), .EXTRA(1'b0)) u_snap_pick (
      .i_map       (i_snap_map),
      .i_extra_bit (1'b0),
      .i_offset    (snap_rel[4:0]),
      .o_byte      (snap_byte)
   );

   bitmap_byte_pick #(.ROWS(ROWS), .COLS(COLS), .EXTRA(1'b0)) u_active_pick (
      .i_map       (state_reg.active),
      .i_extra_bit (1'b0),
      .i_offset    (active_rel[4:0]),
      .o_byte      (active_byte)
   );

   bitmap_byte_pick #(.ROWS(ROWS), .COLS(COLS), .EXTRA(1'b0)) u_snapen_pick (
      .i_map       (state_reg.snap_en),
      .i_extra_bit (1'b0),
      .i_offset    (snapen_rel[4:0]),
      .o_byte      (snapen_byte)
   );

   // ----------------------------------------------------------------
   // count, delta and reference arrays
   // ----------------------------------------------------------------
   // two bytes per channel
   value_store #(.WORDS(ROWS*COLS)) u_count_store (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_wr_en    (i_val_wr_en && (i_val_sel == SEL_COUNT)),
      .i_wr_idx   (i_val_idx),
      .i_wr_val   (i_val_data),
      .i_byte_off (count_rel[8:0]),
      .o_byte     (count_byte)
   );

   value_store #(.WORDS(ROWS*COLS)) u_delta_store (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_wr_en    (i_val_wr_en && (i_val_sel == SEL_DELTA)),
      .i_wr_idx   (i_val_idx),
      .i_wr_val   (i_val_data),
      .i_byte_off (delta_rel[8:0]),
      .o_byte     (delta_byte)
   );

   value_store #(.WORDS(ROWS*COLS)) u_ref_store (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_wr_en    (i_val_wr_en && (i_val_sel == SEL_REF)),
      .i_wr_idx   (i_val_idx),
      .i_wr_val   (i_val_data),
      .i_byte_off (ref_rel[8:0]),
      .o_byte     (ref_byte)
   );

   // ----------------------------------------------------------------
   // system information bytes
   // ----------------------------------------------------------------
   // reset indication
   assign sysinfo_pri = {state_reg.show_reset,
                         state_reg.lowpower_retune_done,
                         state_reg.lowpower_tune_fault,
                         state_reg.pad_retune_done,
                         state_reg.pad_tune_fault,
                         state_reg.mode};
   assign sysinfo_sec = {2'b00,
                         state_reg.switch_state,
                         state_reg.snap_toggle,
                         state_reg.rate_miss,
                         state_reg.finger_over,
                         state_reg.palm,
                         state_reg.motion};

   // ----------------------------------------------------------------
   // read data mux, unmapped addresses read zero
   // ----------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      if (i_rd_addr == ADDR_GEST_SINGLE) begin
         rd_byte = {2'b00, state_reg.gest_single};
      end else if (i_rd_addr == ADDR_GEST_MULTI) begin
         rd_byte = {5'b00000, state_reg.gest_multi};
      end else if (i_rd_addr == ADDR_SYSINFO_PRI) begin
         rd_byte = sysinfo_pri;
      end else if (i_rd_addr == ADDR_SYSINFO_SEC) begin
         rd_byte = sysinfo_sec;
      end else if (prox_rel < PROX_MAP_BYTES) begin
         rd_byte = prox_byte;
      end else if (touch_rel < MAP_BYTES) begin
         rd_byte = touch_byte;
      end else if (snap_rel < MAP_BYTES) begin
         rd_byte = snap_byte;
      end else if (active_rel < MAP_BYTES) begin
         rd_byte = active_byte;
      end else if (snapen_rel < MAP_BYTES) begin
         rd_byte = snapen_byte;
      end else if (count_rel < VAL_BYTES) begin
         rd_byte = count_byte;
      end else if (delta_rel < VAL_BYTES) begin
         rd_byte = delta_byte;
      end else if (ref_rel < VAL_BYTES) begin
         rd_byte = ref_byte;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;

      // host read answer, one cycle after the request
      state_next.rd_valid = i_rd_en;
      if (i_rd_en) begin
         state_next.rd_data = rd_byte;
      end

      // single and multi gesture snapshot
      // a new processing cycle clears the flags; a gesture in the same
      // cycle still lands, so the set wins over the clear
      if (i_gesture_valid) begin
         state_next.gest_single = i_gesture_single;
         state_next.gest_multi  = i_gesture_multi;
      end else if (i_cycle_start) begin
         state_next.gest_single = 6'b000000;
         state_next.gest_multi  = 3'b000;
      end

      state_next.lowpower_retune_done =
         (state_reg.lowpower_retune_done & ~i_cycle_start) | i_lowpower_retune_done;
      state_next.pad_retune_done =
         (state_reg.pad_retune_done & ~i_cycle_start) | i_pad_retune_done;
      state_next.snap_toggle =
         (state_reg.snap_toggle & ~i_cycle_start) | i_snap_change;
      state_next.rate_miss =
         (state_reg.rate_miss & ~i_cycle_start) | i_rate_miss_flag;

      state_next.lowpower_tune_fault = i_lowpower_tune_fault;
      state_next.pad_tune_fault      = i_pad_tune_fault;
      state_next.switch_state        = i_switch_input_pin;
      state_next.finger_over         = i_finger_overflow_flag;
      state_next.palm                = i_palm_flag;
      state_next.motion              = i_pad_motion_flag;

      // mode code
      // codes above the last mode are held off so the field stays legal
      if (i_mode <= MODE_LOW_POWER_SECOND) begin
         state_next.mode = i_mode;
      end

      if (i_wr_en && (i_wr_addr == ADDR_SYSCTRL) && i_wr_data[ACK_RESET_BIT]) begin
         state_next.show_reset = 1'b0;
      end

      // configuration map writes; status addresses ignore writes
      // bit n is column n
      for (int r = 0; r < ROWS; r++) begin
         for (int c = 0; c < COLS; c++) begin
            if (i_wr_en && (wr_active_rel < MAP_BYTES) && (wr_active_rel[4:1] == r[3:0])
                && ((c >= 8) != wr_active_rel[0])) begin
               state_next.active[r*COLS+c] = i_wr_data[c%8];
            end
            if (i_wr_en && (wr_snapen_rel < MAP_BYTES) && (wr_snapen_rel[4:1] == r[3:0])
                && ((c >= 8) != wr_snapen_rel[0])) begin
               state_next.snap_en[r*COLS+c] = i_wr_data[c%8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg            <= '0;
         state_reg.show_reset <= SHOW_RESET_INIT;
         state_reg.active     <= {(ROWS*COLS){MAP_EN_INIT}};
         state_reg.snap_en    <= {(ROWS*COLS){MAP_EN_INIT}};
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, straight from the state register
   // ----------------------------------------------------------------
   assign o_rd_data         = state_reg.rd_data;
   assign o_rd_valid        = state_reg.rd_valid;
   assign o_active_map      = state_reg.active;
   assign o_snap_enable_map = state_reg.snap_en;
   assign o_show_reset      = state_reg.show_reset;

endmodule
`default_nettype wire

// File: touch_status_pkg.sv
// shared constants for the trackpad status reporting bank
// assumes a byte-wide host register map behind a serial host port
`default_nettype none
package touch_status_pkg;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int unsigned TX_ROWS  = 15;
   localparam int unsigned RX_COLS  = 10;
   localparam int unsigned CHANNELS = 150;
   localparam int unsigned VAL_W    = 16;

   // ----------------------------------------------------------------
   // byte addresses of the host map
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_GEST_SINGLE  = 16'h0010;
   localparam logic [15:0] ADDR_GEST_MULTI   = 16'h0011;
   localparam logic [15:0] ADDR_SYSINFO_PRI  = 16'h0012;
   localparam logic [15:0] ADDR_SYSINFO_SEC  = 16'h0013;
   localparam logic [15:0] ADDR_SYSCTRL      = 16'h0014;
   localparam logic [15:0] ADDR_PROX_BASE    = 16'h0020;
   localparam logic [15:0] ADDR_TOUCH_BASE   = 16'h0040;
   localparam logic [15:0] ADDR_SNAP_BASE    = 16'h0060;
   localparam logic [15:0] ADDR_ACTIVE_BASE  = 16'h0080;
   localparam logic [15:0] ADDR_SNAPEN_BASE  = 16'h00A0;
   localparam logic [15:0] ADDR_COUNT_BASE   = 16'h0100;
   localparam logic [15:0] ADDR_DELTA_BASE   = 16'h0300;
   localparam logic [15:0] ADDR_REF_BASE     = 16'h0500;

   // lengths of the blocks in bytes
   localparam logic [15:0] MAP_BYTES      = 16'h001E;
   localparam logic [15:0] PROX_MAP_BYTES = 16'h0020;
   localparam logic [15:0] VAL_BYTES      = 16'h012C;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned ACK_RESET_BIT = 7;
   localparam logic        SHOW_RESET_INIT = 1'b1;
   localparam logic        MAP_EN_INIT     = 1'b1;

   // value array selector on the sensing write port
   localparam logic [1:0] SEL_COUNT = 2'h0;
   localparam logic [1:0] SEL_DELTA = 2'h1;
   localparam logic [1:0] SEL_REF   = 2'h2;

   // operating mode codes
   typedef enum logic [2:0] {
      MODE_ACTIVE           = 3'h0,
      MODE_IDLE_TOUCH       = 3'h1,
      MODE_IDLE             = 3'h2,
      MODE_LOW_POWER_FIRST  = 3'h3,
      MODE_LOW_POWER_SECOND = 3'h4
   } op_mode_t;

endpackage
`default_nettype wire

// File: bitmap_byte_pick.sv
// picks one byte of a row-word channel bitmap, high byte first
// assumes the offset is already relative to the bitmap base
`timescale 1ns/10ps
`default_nettype none
module bitmap_byte_pick import touch_status_pkg::*; #(
   parameter int unsigned ROWS  = TX_ROWS,
   parameter int unsigned COLS  = RX_COLS,
   parameter bit          EXTRA = 1'b0
) (
   input  wire logic [ROWS*COLS-1:0] i_map,
   input  wire logic                 i_extra_bit,
   input  wire logic [4:0]           i_offset,
   output logic      [7:0]           o_byte
);

   // ----------------------------------------------------------------
   // row word build and lane select
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] word;
      word = '0;
      for (int r = 0; r < ROWS; r++) begin
         if (i_offset[4:1] == r[3:0]) begin
            word[COLS-1:0] = i_map[r*COLS +: COLS];
         end
      end
      // trailing word carries only the extra proximity bit
      if (EXTRA && (i_offset[4:1] == ROWS[3:0])) begin
         word = {15'h0000, i_extra_bit};
      end
      o_byte = i_offset[0] ? word[7:0] : word[15:8];
   end

endmodule
`default_nettype wire

// File: value_store.sv
// one per-channel 16-bit value array with a byte read port
// assumes writes come from the sensing engine, reads from the host side
`timescale 1ns/10ps
`default_nettype none
module value_store import touch_status_pkg::*; #(
   parameter int unsigned WORDS = CHANNELS
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_wr_en,
   input  wire logic [7:0]  i_wr_idx,
   input  wire logic [15:0] i_wr_val,
   input  wire logic [8:0]  i_byte_off,
   output logic      [7:0]  o_byte
);

   logic [15:0] mem_reg [WORDS];
   logic [15:0] word;

   // ----------------------------------------------------------------
   // storage, cleared at reset so reads never return unknowns
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int w = 0; w < WORDS; w++) begin
            mem_reg[w] <= 16'h0000;
         end
      end else if (i_wr_en && (i_wr_idx < WORDS[7:0])) begin
         mem_reg[i_wr_idx] <= i_wr_val;
      end
   end

   // index [tx][rx] is tx*cols+rx, two bytes each, high byte first
   always_comb begin
      word = 16'h0000;
      if (i_byte_off[8:1] < WORDS[7:0]) begin
         word = mem_reg[i_byte_off[8:1]];
      end
      o_byte = i_byte_off[0] ? word[7:0] : word[15:8];
   end

endmodule
`default_nettype wire

// File: touch_status_report_regs_sva.sv
// checker for the trackpad status bank host port
// assumes it is bound to touch_status_report_regs, one clock domain
`timescale 1ns/10ps
`default_nettype none
module touch_status_report_regs_sva import touch_status_pkg::*; (
   input wire logic        i_core_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_rd_en,
   input wire logic [15:0] i_rd_addr,
   input wire logic        i_wr_en,
   input wire logic [15:0] i_wr_addr,
   input wire logic [7:0]  i_wr_data,
   input wire logic [2:0]  i_mode,
   input wire logic        i_switch_input_pin,
   input wire logic        i_alt_lowpower_prox,
   input wire logic [7:0]  o_rd_data,
   input wire logic        o_rd_valid,
   input wire logic        o_show_reset
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // ----------------------------------------------------------------
   // host read answers and register fields
   // ----------------------------------------------------------------
   a_read_answer: assert property (i_rd_en |=> o_rd_valid) else $error("read not answered");
   a_no_spurious: assert property (!i_rd_en |=> !o_rd_valid) else $error("valid without read");
   a_ack_clears: assert property (
      i_wr_en && i_wr_addr == ADDR_SYSCTRL && i_wr_data[7] |=> !o_show_reset) else $error("ack ignored");
   a_flag_sticky: assert property (!o_show_reset |=> !o_show_reset) else $error("reset flag set");
   a_single_spare: assert property (
      i_rd_en && i_rd_addr == ADDR_GEST_SINGLE |=> o_rd_data[7:6] == 2'h0) else $error("gesture spare");
   a_multi_spare: assert property (
      i_rd_en && i_rd_addr == ADDR_GEST_MULTI |=> o_rd_data[7:3] == 5'h00) else $error("multi spare");
   a_info_spare: assert property (
      i_rd_en && i_rd_addr == ADDR_SYSINFO_SEC |=> o_rd_data[7:6] == 2'h0) else $error("info spare");
   // levels are registered, so the read shows the input from one edge before the request
   a_mode_code: assert property (
      i_rd_en && i_rd_addr == ADDR_SYSINFO_PRI && $past(i_mode) < 3'h5 && !$past(i_sys_rst)
      |=> o_rd_data[2:0] == $past(i_mode, 2)) else $error("mode code wrong");
   a_switch_level: assert property (
      i_rd_en && i_rd_addr == ADDR_SYSINFO_SEC && !$past(i_sys_rst)
      |=> o_rd_data[5] == $past(i_switch_input_pin, 2)) else $error("switch level wrong");
   a_prox_tail: assert property (
      i_rd_en && i_rd_addr == ADDR_PROX_BASE + 16'h001F
      |=> o_rd_data == {7'h00, $past(i_alt_lowpower_prox)}) else $error("prox tail wrong");
endmodule

bind touch_status_report_regs touch_status_report_regs_sva chk (.i_core_clk, .i_sys_rst, .i_rd_en, .i_rd_addr,
   .i_wr_en, .i_wr_addr, .i_wr_data, .i_mode, .i_switch_input_pin, .i_alt_lowpower_prox, .o_rd_data,
   .o_rd_valid, .o_show_reset);
`default_nettype wire

// File: touch_host_model.sv
// host side model issuing byte reads and writes to the status bank
// assumes one request at a time, answer one cycle after it is taken
`timescale 1ns/10ps
`default_nettype none
module touch_host_model (
   input  wire logic        i_core_clk,
   input  wire logic [7:0]  i_rd_data,
   input  wire logic        i_rd_valid,
   output logic             o_rd_en,
   output logic      [15:0] o_rd_addr,
   output logic             o_wr_en,
   output logic      [15:0] o_wr_addr,
   output logic      [7:0]  o_wr_data
);
   // ----------------------------------------------------------------
   // byte transfers
   // ----------------------------------------------------------------
   initial begin
      {o_rd_en, o_wr_en, o_rd_addr, o_wr_addr, o_wr_data} = '0;
   end
   // released lines show inverted values so stale data cannot pass for good
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
      @(posedge i_core_clk);
      o_rd_en <= 1'b1;
      o_rd_addr <= a;
      @(posedge i_core_clk);
      o_rd_en <= 1'b0;
      o_rd_addr <= ~a;
      #1;
      for (int n = 0; n < 4 && i_rd_valid !== 1'b1; n++) @(posedge i_core_clk) #1;
      ok = (i_rd_valid === 1'b1);
      d = i_rd_data;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge i_core_clk);
      o_wr_en <= 1'b1;
      o_wr_addr <= a;
      o_wr_data <= v;
      @(posedge i_core_clk);
      o_wr_en <= 1'b0;
      o_wr_addr <= ~a;
      o_wr_data <= ~v;
      #1;
   endtask
endmodule
`default_nettype wire

// File: touch_status_report_regs_bench.sv
// self-checking bench for the trackpad status bank
// assumes the host model and the checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module touch_status_report_regs_bench import touch_status_pkg::*;;
   logic i_core_clk, i_sys_rst, i_rd_en, i_wr_en, i_cycle_start, i_gesture_valid, i_lowpower_retune_done;
   logic i_lowpower_tune_fault, i_pad_retune_done, i_pad_tune_fault, i_switch_input_pin, i_snap_change;
   logic i_rate_miss_flag, i_finger_overflow_flag, i_palm_flag, i_pad_motion_flag, i_alt_lowpower_prox;
   logic i_val_wr_en, o_rd_valid, o_show_reset;
   logic [15:0]  i_rd_addr, i_wr_addr, i_val_data;
   logic [7:0]   i_wr_data, o_rd_data, i_val_idx;
   logic [5:0]   i_gesture_single;
   logic [2:0]   i_gesture_multi, i_mode;
   logic [1:0]   i_val_sel;
   logic [149:0] i_prox_map, i_touch_map, i_snap_map, o_active_map, o_snap_enable_map;
   int           bad_count, check_count;
   typedef struct packed {logic [15:0] addr; logic [8:0] lv; logic [7:0] exp;} row_t;
   // lv is mode, low-power fault, pad fault, switch, overflow, palm, motion
   row_t rows [10] = '{'{ADDR_SYSINFO_PRI, 9'h020, 8'hA0}, '{ADDR_SYSINFO_PRI, 9'h050, 8'h89},
      '{ADDR_SYSINFO_PRI, 9'h080, 8'h82}, '{ADDR_SYSINFO_PRI, 9'h0C0, 8'h83}, '{ADDR_SYSINFO_PRI, 9'h100, 8'h84},
      '{ADDR_SYSINFO_SEC, 9'h108, 8'h20}, '{ADDR_SYSINFO_SEC, 9'h104, 8'h04}, '{ADDR_SYSINFO_SEC, 9'h102, 8'h02},
      '{ADDR_SYSINFO_SEC, 9'h101, 8'h01}, '{16'h0000, 9'h100, 8'h00}};
   logic [15:0] bases [3] = '{ADDR_COUNT_BASE, ADDR_DELTA_BASE, ADDR_REF_BASE};
   logic [1:0]  sels [3] = '{SEL_COUNT, SEL_DELTA, SEL_REF};
   touch_status_report_regs uut (.*);
   touch_host_model host (.i_core_clk, .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid), .o_rd_en(i_rd_en),
      .o_rd_addr(i_rd_addr), .o_wr_en(i_wr_en), .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data));
   // ----------------------------------------------------------------
   // clock, helpers and closing report
   // ----------------------------------------------------------------
   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // a lost answer ends the run instead of hanging
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      bit ok;
      host.rd(a, d, ok);
      if (!ok) begin bad_count++; results(); end
      `CHK(d, e)
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {i_cycle_start, i_gesture_valid, i_gesture_single, i_gesture_multi, i_lowpower_retune_done,
       i_lowpower_tune_fault, i_pad_retune_done, i_pad_tune_fault, i_mode, i_switch_input_pin, i_snap_change,
       i_rate_miss_flag, i_finger_overflow_flag, i_palm_flag, i_pad_motion_flag, i_prox_map, i_touch_map,
       i_snap_map, i_alt_lowpower_prox, i_val_wr_en, i_val_sel, i_val_idx, i_val_data} = '0;
      i_sys_rst = 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      `CHK(o_show_reset, 1'b1)
      `CHK(o_active_map, {150{1'b1}})
      foreach (rows[i]) begin
         @(posedge i_core_clk);
         {i_mode, i_lowpower_tune_fault, i_pad_tune_fault, i_switch_input_pin, i_finger_overflow_flag,
          i_palm_flag, i_pad_motion_flag} <= rows[i].lv;
         rchk(rows[i].addr, rows[i].exp);
      end
      $display("end of status table");
      // event pulses stay up until the next processing cycle
      @(posedge i_core_clk);
      {i_lowpower_retune_done, i_pad_retune_done, i_snap_change, i_rate_miss_flag} <= 4'hF;
      @(posedge i_core_clk);
      {i_lowpower_retune_done, i_pad_retune_done, i_snap_change, i_rate_miss_flag} <= 4'h0;
      rchk(ADDR_SYSINFO_PRI, 8'hD4);
      rchk(ADDR_SYSINFO_SEC, 8'h18);
      @(posedge i_core_clk);
      i_cycle_start <= 1'b1;
      @(posedge i_core_clk);
      i_cycle_start <= 1'b0;
      rchk(ADDR_SYSINFO_PRI, 8'h84);
      rchk(ADDR_SYSINFO_SEC, 8'h00);
      $display("end of event flags");
      for (int k = 0; k < 6; k++) begin
         @(posedge i_core_clk);
         i_gesture_valid <= 1'b1;
         i_cycle_start <= 1'b1; // set wins
         i_gesture_single <= 6'h01 << k;
         i_gesture_multi <= 3'h1 << (k % 3);
         @(posedge i_core_clk);
         {i_gesture_valid, i_cycle_start} <= 2'b00;
         rchk(ADDR_GEST_SINGLE, 8'h01 << k);
         rchk(ADDR_GEST_MULTI, 8'h01 << (k % 3));
      end
      host.wr(ADDR_GEST_SINGLE, 8'hFF);
      rchk(ADDR_GEST_SINGLE, 8'h20);
      host.wr(ADDR_SYSCTRL, 8'h80);
      `CHK(o_show_reset, 1'b0)
      rchk(ADDR_SYSINFO_PRI, 8'h04);
      $display("end of gestures and reset flag");
      @(posedge i_core_clk);
      i_touch_map <= (150'h1 << 149) | (150'h1 << 146);
      i_snap_map <= 150'h1;
      i_alt_lowpower_prox <= 1'b1;
      rchk(ADDR_TOUCH_BASE + 16'h001C, 8'h02);
      rchk(ADDR_TOUCH_BASE + 16'h001D, 8'h40);
      rchk(ADDR_SNAP_BASE + 16'h0001, 8'h01);
      rchk(ADDR_PROX_BASE + 16'h001F, 8'h01);
      rchk(ADDR_PROX_BASE + 16'h001E, 8'h00);
      host.wr(ADDR_ACTIVE_BASE, 8'hFC);
      `CHK(o_active_map[9:8], 2'b00)
      rchk(ADDR_ACTIVE_BASE, 8'h00);
      host.wr(ADDR_SNAPEN_BASE + 16'h001D, 8'h0F);
      `CHK(o_snap_enable_map[149:140], 10'h30F)
      $display("end of channel maps");
      foreach (bases[s]) begin
         @(posedge i_core_clk);
         i_val_wr_en <= 1'b1;
         i_val_sel <= sels[s];
         i_val_idx <= 8'h95;
         i_val_data <= {8'hA5, 6'h30, sels[s]};
         @(posedge i_core_clk);
         i_val_wr_en <= 1'b0;
         rchk(bases[s] + 16'h012A, 8'hA5);
         rchk(bases[s] + 16'h012B, {6'h30, sels[s]});
      end
      $display("end of value arrays");
      results();
   end
endmodule
`default_nettype wire
